// ---- design/can_rx_fifo_pointer_logic.sv ----
/*
 * Receive FIFO pointer logic for the message buffers of a CAN controller,
 * with an AXI4-Lite register slave. Assumes the filters and the receive DMA
 * path run on aclk and that software follows the unload order.
 */
// Added by the designer: the address map and register access over AXI4-Lite.
// Notes on behaviour
// - Count code selects 4 to 32 buffers.
// - Five-bit start field gives first FIFO buffer.
// - Region ends at highest buffer of area.
// - Filter pointer 1111 steers message into FIFO.
// - Write pointer advances, wraps end to start.
// - Write pointer readable in status bits 13:8.
// - Store sets full flag and pointer advances on the same edge.
// - Already full buffer: overflow, drop, advance.
// - Transmit buffer at pointer: overflow, drop, advance.
// - Refused FIFO write raises overflow interrupt.
// - Clearing full flag loads next-read with n+1.
// - Almost full: read minus write one, or wrap.
// - Almost-full judged with updated write pointer.
// - Completely full raises no interrupt itself.
// - Before any message, pointer holds start index.
// - Buffers 0-7 switchable, 8-31 receive only.
// - Store raises receive flag; overflow raises overflow flag.
`include "rxfifo_defines.svh"

module can_rx_fifo_pointer_logic
#(
    parameter int unsigned ADDR_W = 8
)
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      clk_en,
    input  wire logic [ADDR_W-1:0]         awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [ADDR_W-1:0]         araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    input  wire rxfifo_pkg::filter_hit_t   hit,
    output rxfifo_pkg::store_req_t         store,
    output logic                           rx_buffer_flag,
    output logic                           rx_overflow_flag,
    output logic                           almost_full_flag
);
    import rxfifo_pkg::*;

    // Decodes a byte address into a register select.
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
        case (a[7:0])
            `OFS_CTRL:   decode = REG_CTRL;
            `OFS_STATUS: decode = REG_STATUS;
            `OFS_INTF:   decode = REG_INTF;
            `OFS_FULL:   decode = REG_FULL;
            `OFS_OVL:    decode = REG_OVL;
            `OFS_DIR:    decode = REG_DIR;
            default:     decode = REG_NONE;
        endcase
    endfunction : decode

    // Widens the byte strobes into a bit mask.
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : lane_mask

    // Highest buffer number whose bit is set.
    function automatic logic [4:0] top_index(input logic [31:0] m);
        top_index = 5'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (m[i])
            begin
                top_index = 5'(i);
            end
        end
    endfunction : top_index

    wr_state_t   wr_state_r;
    logic [15:0] ctrl_r;
    logic [5:0]  wp_r;
    logic [5:0]  nr_r;
    logic [31:0] full_r;
    logic [31:0] ovl_r;
    logic [7:0]  dir_r;
    logic [2:0]  intf_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
    store_req_t  store_r;
    logic        wr_take;
    logic        rd_take;
    reg_sel_t    wsel;
    reg_sel_t    rsel;
    logic [31:0] bmask;
    logic [31:0] wbits;
    logic [15:0] ctrl_nxt;
    logic        ctrl_wr;
    logic [31:0] clr_full;
    logic [31:0] clr_ovl;
    logic [2:0]  clr_intf;
    logic [4:0]  start;
    logic [4:0]  idx;
    logic        hit_fifo;
    logic        tx_busy;
    logic        store_ev;
    logic        ovf_ev;
    logic [31:0] idx_bit;
    logic [5:0]  end_idx;
    logic [5:0]  wp_adv;
    logic        af_next;

    // Write address and data are taken together in one edge.
    assign awready = clk_en && (wr_state_r == WR_IDLE) && wvalid;
    assign wready  = clk_en && (wr_state_r == WR_IDLE) && awvalid;
    assign wr_take = awready && awvalid;
    assign arready = clk_en && !rvalid_r;
    assign rd_take = arready && arvalid;
    assign bvalid  = (wr_state_r == WR_RESP);
    assign bresp   = bresp_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    // Write decode; the one-to-clear registers use the strobed data bits.
    assign wsel     = decode(awaddr);
    assign rsel     = decode(araddr);
    assign bmask    = lane_mask(wstrb);
    assign wbits    = wdata & bmask;
    assign ctrl_nxt = ((ctrl_r & ~bmask[15:0]) | wbits[15:0]) & `CTRL_MASK;
    assign ctrl_wr  = wr_take && (wsel == REG_CTRL);
    assign clr_full = (wr_take && (wsel == REG_FULL)) ? wbits : 32'h0000_0000;
    assign clr_ovl  = (wr_take && (wsel == REG_OVL)) ? wbits : 32'h0000_0000;
    assign clr_intf = (wr_take && (wsel == REG_INTF)) ? wbits[3:1] : 3'h0;

    // Filter hit qualification against the buffer at the write pointer.
    assign start    = ctrl_r[`CTRL_START_HI:`CTRL_START_LO];
    assign idx      = wp_r[4:0];
    assign idx_bit  = 32'h0000_0001 << idx;
    assign hit_fifo = clk_en && hit.valid && (hit.filter_buffer_pointer == `BP_FIFO);
    assign tx_busy  = (idx < `TX_CAPABLE) && dir_r[idx[2:0]];
    assign ovf_ev   = hit_fifo && (full_r[idx] || tx_busy);
    assign store_ev = hit_fifo && !ovf_ev;

    fifo_ptr_step u_step
    (
        .buffer_count_sel   (ctrl_r[`CTRL_SEL_HI:`CTRL_SEL_LO]),
        .fifo_start_index   (start),
        .fifo_write_pointer (wp_r),
        .fifo_next_read     (nr_r),
        .end_idx            (end_idx),
        .wp_adv             (wp_adv),
        .almost_full        (af_next)
    );

    // Write channel state and response code.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_r <= WR_IDLE;
            bresp_r    <= `RESP_OKAY;
        end
        else if (clk_en)
        begin
            case (wr_state_r)
                WR_IDLE:
                begin
                    if (wr_take)
                    begin
                        wr_state_r <= WR_RESP;
                        bresp_r    <= (wsel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
                    end
                end
                WR_RESP:
                begin
                    if (bready)
                    begin
                        wr_state_r <= WR_IDLE;
                    end
                end
                default: wr_state_r <= WR_IDLE;
            endcase
        end
    end

    // Read channel; data is captured at the address edge.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (rd_take)
            begin
                rvalid_r <= 1'b1;
                rresp_r  <= (rsel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
                case (rsel)
                    REG_CTRL:   rdata_r <= {16'h0000, ctrl_r};
                    REG_STATUS: rdata_r <= {18'h00000, wp_r, 2'h0, nr_r};
                    REG_INTF:   rdata_r <= {28'h0000000, intf_r, 1'b0};
                    REG_FULL:   rdata_r <= full_r;
                    REG_OVL:    rdata_r <= ovl_r;
                    REG_DIR:    rdata_r <= {24'h000000, dir_r};
                    default:    rdata_r <= 32'h0000_0000;
                endcase
            end
            else if (rready)
            begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // Control and direction registers written by software.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= `CTRL_RST;
            dir_r  <= 8'h00;
        end
        else if (clk_en && wr_take)
        begin
            if (wsel == REG_CTRL)
            begin
                ctrl_r <= ctrl_nxt;
            end
            if (wsel == REG_DIR)
            begin
                dir_r <= (dir_r & ~bmask[7:0]) | wbits[7:0];
            end
        end
    end

    // Write pointer: reloaded on control writes, else stepped on every FIFO hit.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wp_r <= {1'b0, 5'(`CTRL_RST >> `CTRL_START_LO)};
        end
        else if (clk_en)
        begin
            if (ctrl_wr)
            begin
                wp_r <= {1'b0, ctrl_nxt[`CTRL_START_HI:`CTRL_START_LO]};
            end
            else if (hit_fifo)
            begin
                wp_r <= wp_adv;
            end
        end
    end

    // Next-read field follows the last full flag that software cleared.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            nr_r <= {1'b0, 5'(`CTRL_RST >> `CTRL_START_LO)};
        end
        else if (clk_en)
        begin
            if (ctrl_wr)
            begin
                nr_r <= {1'b0, ctrl_nxt[`CTRL_START_HI:`CTRL_START_LO]};
            end
            else if (|clr_full)
            begin
                nr_r <= {1'b0, top_index(clr_full)} + 6'h01;
            end
        end
    end

    // Per-buffer full and overflow flags; a hardware set beats a clear.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            full_r <= 32'h0000_0000;
            ovl_r  <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            full_r <= (full_r & ~clr_full) | (store_ev ? idx_bit : 32'h0000_0000);
            ovl_r  <= (ovl_r & ~clr_ovl) | (ovf_ev ? idx_bit : 32'h0000_0000);
        end
    end

    // Sticky interrupt flags, cleared by writing ones.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            intf_r <= 3'h0;
        end
        else if (clk_en)
        begin
            intf_r[`INTF_RXB] <= store_ev || (intf_r[`INTF_RXB] && !clr_intf[`INTF_RXB]);
            intf_r[`INTF_OVF] <= ovf_ev || (intf_r[`INTF_OVF] && !clr_intf[`INTF_OVF]);
            // Only a store that leaves one slot free raises this; full alone does not.
            intf_r[`INTF_AF]  <= (store_ev && af_next)
                              || (intf_r[`INTF_AF] && !clr_intf[`INTF_AF]);
        end
    end

    // Store order to the receive DMA path, one pulse per accepted message.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            store_r <= '0;
        end
        else if (clk_en)
        begin
            store_r.valid <= store_ev;
            store_r.index <= idx;
        end
    end

    assign store            = store_r;
    assign rx_buffer_flag   = intf_r[`INTF_RXB];
    assign rx_overflow_flag = intf_r[`INTF_OVF];
    assign almost_full_flag = intf_r[`INTF_AF];

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Helper copies of the hit context for the checks below.
    logic [4:0] chk_idx_r;
    logic [5:0] chk_start_r;
    always_ff @(posedge aclk)
    begin
        chk_idx_r   <= idx;
        chk_start_r <= {1'b0, start};
    end

    a_wp_wrap: assert property (hit_fifo && !ctrl_wr && (wp_r == end_idx) |=> wp_r == chk_start_r)
        else $error("write pointer did not wrap to start");
    a_wp_step: assert property (hit_fifo && !ctrl_wr && (wp_r != end_idx) |=> wp_r == $past(wp_r) + 6'h01)
        else $error("write pointer did not step by one");
    a_full_set: assert property (store_ev |=> full_r[chk_idx_r] && store.valid && store.index == chk_idx_r)
        else $error("store did not set full flag");
    a_ovl_drop: assert property (ovf_ev |=> ovl_r[chk_idx_r] && !store.valid && rx_overflow_flag)
        else $error("overflow not flagged or message kept");
    a_ctrl_reload: assert property (ctrl_wr |=> (wp_r == {1'b0, start}) && (nr_r == {1'b0, start}))
        else $error("control write did not reload pointers");
    a_next_read: assert property (clk_en && !ctrl_wr && |clr_full |=> nr_r == {1'b0, top_index($past(clr_full))} + 6'h01)
        else $error("next-read not loaded with buffer plus one");
    a_af_cause: assert property ($rose(almost_full_flag) |-> $past(store_ev) && $past(af_next))
        else $error("almost-full raised without cause");
    a_af_sticky: assert property (almost_full_flag && !clr_intf[`INTF_AF] && clk_en |=> almost_full_flag)
        else $error("almost-full flag dropped on its own");
    a_rx_flag: assert property (store_ev |=> rx_buffer_flag)
        else $error("receive flag not raised on store");

    c_wrap: cover property (store_ev && (wp_r == end_idx));
    c_overflow: cover property (ovf_ev && full_r[idx]);
    c_tx_refuse: cover property (ovf_ev && tx_busy);
    c_almost_full: cover property (store_ev && af_next);

endmodule : can_rx_fifo_pointer_logic

// ---- design/rxfifo_defines.svh ----
/*
 * Register offsets, field positions, reset values and encodings of the
 * receive FIFO pointer block. Assumes inclusion by bare name only.
 */
`ifndef RXFIFO_DEFINES_SVH
`define RXFIFO_DEFINES_SVH

// Byte offsets of the register words on the AXI4-Lite slave.
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_INTF      8'h08
`define OFS_FULL      8'h0c
`define OFS_OVL       8'h10
`define OFS_DIR       8'h14

// Field positions, mask and reset value of fifo_control.
`define CTRL_SEL_HI   15
`define CTRL_SEL_LO   13
`define CTRL_START_HI 4
`define CTRL_START_LO 0
`define CTRL_MASK     16'he01f
`define CTRL_RST      16'h0000

// Interrupt flag positions inside the three-bit flag vector.
`define INTF_RXB      0
`define INTF_OVF      1
`define INTF_AF       2

// Filter pointer code that selects the circular region.
`define BP_FIFO       4'hf
// Buffers below this index may be switched to transmit.
`define TX_CAPABLE    5'h08

// Buffer counts selected by the three-bit count code.
`define CNT_C0        6'h04
`define CNT_C1        6'h06
`define CNT_C2        6'h08
`define CNT_C3        6'h0c
`define CNT_C4        6'h10
`define CNT_C5        6'h18
`define CNT_MAX       6'h20

// AXI response codes.
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ---- design/rxfifo_pkg.sv ----
/*
 * Types shared by the receive FIFO pointer block.
 * Assumes nothing of its surroundings.
 */
package rxfifo_pkg;

    // One filter hit from the acceptance filters.
    typedef struct packed {
        logic       valid;
        logic [3:0] filter_buffer_pointer;
    } filter_hit_t;

    // One store order to the receive DMA path.
    typedef struct packed {
        logic       valid;
        logic [4:0] index;
    } store_req_t;

    // Register selected by a bus address.
    typedef enum logic [2:0] {
        REG_CTRL,
        REG_STATUS,
        REG_INTF,
        REG_FULL,
        REG_OVL,
        REG_DIR,
        REG_NONE
    } reg_sel_t;

    // Write channel states.
    typedef enum logic {
        WR_IDLE = 1'b0,
        WR_RESP = 1'b1
    } wr_state_t;

endpackage : rxfifo_pkg

// ---- design/fifo_ptr_step.sv ----
/*
 * Combinational step of the circular write pointer and the almost-full test.
 * Assumes pointer values come from flip-flops on the same clock.
 */
`include "rxfifo_defines.svh"

module fifo_ptr_step
(
    input  wire logic [2:0] buffer_count_sel,
    input  wire logic [4:0] fifo_start_index,
    input  wire logic [5:0] fifo_write_pointer,
    input  wire logic [5:0] fifo_next_read,
    output logic      [5:0] end_idx,
    output logic      [5:0] wp_adv,
    output logic            almost_full
);

    // Maps the count code to the number of buffers in the area.
    function automatic logic [5:0] buffer_total(input logic [2:0] sel);
        case (sel)
            3'h0:    buffer_total = `CNT_C0;
            3'h1:    buffer_total = `CNT_C1;
            3'h2:    buffer_total = `CNT_C2;
            3'h3:    buffer_total = `CNT_C3;
            3'h4:    buffer_total = `CNT_C4;
            3'h5:    buffer_total = `CNT_C5;
            default: buffer_total = `CNT_MAX;
        endcase
    endfunction : buffer_total

    logic [5:0] start6;

    // The end is the highest buffer of the allocated area.
    assign start6  = {1'b0, fifo_start_index};
    assign end_idx = buffer_total(buffer_count_sel) - 6'h01;

    // After the end the pointer reloads the start instead of counting on.
    assign wp_adv = (fifo_write_pointer == end_idx) ? start6 : fifo_write_pointer + 6'h01;

    // Almost full, judged on the pointer value after the write.
    assign almost_full = ((fifo_next_read - wp_adv) == 6'h01)
                       || ((fifo_next_read == start6) && (wp_adv == end_idx));

endmodule : fifo_ptr_step

// ---- tb/filter_model.sv ----
/*
 * Behavioural acceptance filter stage that hands one filter hit to the block.
 * Assumes the bench raises go for one aclk cycle per hit, off the sampling edge.
 */
module filter_model
(
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    go,
    input  wire logic [3:0]              code,
    output rxfifo_pkg::filter_hit_t      hit
);
    timeunit 1ns;
    timeprecision 1ps;
    import rxfifo_pkg::*;

    // A hit stands one cycle; between hits the pointer field toggles so a stale code never looks steady.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hit.valid                 <= 1'b0;
            hit.filter_buffer_pointer <= 4'h0;
        end
        else
        begin
            hit.valid                 <= go;
            hit.filter_buffer_pointer <= go ? code : ~hit.filter_buffer_pointer;
        end
    end
endmodule : filter_model

// ---- tb/can_rx_fifo_pointer_logic_tb_top.sv ----
/*
 * Self-checking bench for the receive FIFO pointer block: bus tasks, filter hits and FIFO scenarios.
 * Assumes the design files and the filter model are compiled before it.
 */
`include "rxfifo_defines.svh"

module can_rx_fifo_pointer_logic_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rxfifo_pkg::*;

    logic        aclk, aresetn, clk_en, awvalid, wvalid, bready, arvalid, rready, go;
    logic        awready, wready, bvalid, arready, rvalid, rx_buffer_flag, rx_overflow_flag, almost_full_flag;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, code;
    logic [1:0]  bresp, rresp;
    filter_hit_t hit;
    store_req_t  store;
    int          err_count, n_tests;

    can_rx_fifo_pointer_logic #(.ADDR_W(8)) uut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .hit(hit),
        .store(store), .rx_buffer_flag(rx_buffer_flag), .rx_overflow_flag(rx_overflow_flag),
        .almost_full_flag(almost_full_flag));

    filter_model partner (.aclk(aclk), .aresetn(aresetn), .go(go), .code(code), .hit(hit));

    // Free-running 50 MHz clock.
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Prints the verdict and ends the run.
    task automatic wrap_up();
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Compares one value and counts the result.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Ends the run when a handshake has waited too long.
    task automatic stall(input int n);
        if (n > 50)
        begin
            err_count++;
            $display("[ERR] handshake expected within 50 cycles seen none");
            wrap_up();
        end
    endtask : stall

    // One AXI4-Lite write; address and data are offered together and held until taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        @(negedge aclk);
        for (n = 0; !(awready === 1'b1 && wready === 1'b1); n++)
        begin
            stall(n);
            @(negedge aclk);
        end
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        @(negedge aclk);
        for (n = 0; bvalid !== 1'b1; n++)
        begin
            stall(n);
            @(negedge aclk);
        end
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask : axi_wr

    // One AXI4-Lite read.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        @(negedge aclk);
        for (n = 0; arready !== 1'b1; n++)
        begin
            stall(n);
            @(negedge aclk);
        end
        @(posedge aclk);
        arvalid <= 1'b0;
        @(negedge aclk);
        for (n = 0; rvalid !== 1'b1; n++)
        begin
            stall(n);
            @(negedge aclk);
        end
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : axi_rd

    // Write that must be answered OKAY.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
        chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, r});
    endtask : wr

    // Read of a register whose value is known.
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(what, exp, d);
    endtask : rd_chk

    // Status word: write pointer in 13:8, next read in 5:0.
    task automatic chk_status(input logic [5:0] wp, input logic [5:0] nr);
        rd_chk("fifo_status", `OFS_STATUS, {18'h0, wp, 2'h0, nr});
    endtask : chk_status

    // One filter hit, then a check of the store order that follows it.
    task automatic send_hit(input logic [3:0] c, input logic exp_st, input logic [4:0] idx);
        @(posedge aclk);
        go   <= 1'b1;
        code <= c;
        @(posedge aclk);
        go <= 1'b0;
        @(posedge aclk);
        @(negedge aclk);
        chk("store_valid", {31'h0, exp_st}, {31'h0, store.valid});
        if (exp_st)
            chk("store_index", {27'h0, idx}, {27'h0, store.index});
    endtask : send_hit

    // Clears every full, overflow and interrupt flag.
    task automatic clr_all();
        wr(`OFS_FULL, 32'hffffffff);
        wr(`OFS_OVL, 32'hffffffff);
        wr(`OFS_INTF, 32'hffffffff);
    endtask : clr_all

    // Buffer count for each count code.
    function automatic int cnt(input int c);
        int t[8] = '{4, 6, 8, 12, 16, 24, 32, 32};
        return t[c];
    endfunction : cnt

    // Reset state of control and status.
    task automatic t_reset();
        rd_chk("fifo_control", `OFS_CTRL, 32'h0);
        chk_status(6'h00, 6'h00);
    endtask : t_reset

    // Every count code: two hits from start = end - 1 must wrap back to start.
    task automatic t_codes();
        int s;
        for (int c = 0; c < 8; c++)
        begin
            s = cnt(c) - 2;
            clr_all();
            wr(`OFS_CTRL, {16'h0, c[2:0], 8'h0, s[4:0]});
            chk_status(s[5:0], s[5:0]);
            send_hit(4'hf, 1'b1, s[4:0]);
            send_hit(4'hf, 1'b1, s[4:0] + 5'h1);
            chk_status(s[5:0], s[5:0]);
        end
    endtask : t_codes

    // Region 5..11 walked through fill, first read, wrap, full and overflow.
    task automatic t_fill();
        clr_all();
        wr(`OFS_CTRL, 32'h00006005);
        chk_status(6'd5, 6'd5);
        for (int i = 0; i < 6; i++)
        begin
            send_hit(4'hf, 1'b1, 5'(5 + i));
            if (i == 4)
                chk("almost_full_flag", 32'h0, {31'h0, almost_full_flag});
        end
        chk_status(6'd11, 6'd5);
        chk("almost_full_flag", 32'h1, {31'h0, almost_full_flag});
        chk("rx_buffer_flag", 32'h1, {31'h0, rx_buffer_flag});
        rd_chk("full_flags", `OFS_FULL, 32'h000007e0);
        wr(`OFS_INTF, 32'hffffffff);
        chk("almost_full_flag", 32'h0, {31'h0, almost_full_flag});
        wr(`OFS_FULL, 32'h00000020);
        chk_status(6'd11, 6'd6);
        send_hit(4'hf, 1'b1, 5'd11);
        chk_status(6'd5, 6'd6);
        chk("almost_full_flag", 32'h1, {31'h0, almost_full_flag});
        wr(`OFS_INTF, 32'hffffffff);
        send_hit(4'hf, 1'b1, 5'd5);
        chk("almost_full_flag", 32'h0, {31'h0, almost_full_flag});
        chk("rx_overflow_flag", 32'h0, {31'h0, rx_overflow_flag});
        send_hit(4'hf, 1'b0, 5'd0);
        chk("rx_overflow_flag", 32'h1, {31'h0, rx_overflow_flag});
        rd_chk("ovl_flags", `OFS_OVL, 32'h00000040);
        rd_chk("full_flags", `OFS_FULL, 32'h00000fe0);
        chk_status(6'd7, 6'd6);
    endtask : t_fill

    // A FIFO hit while the clock enable is low, and every other pointer code, leave the region alone.
    task automatic t_steer();
        clk_en <= 1'b0;
        send_hit(4'hf, 1'b0, 5'd0);
        @(posedge aclk) clk_en <= 1'b1;
        for (int c = 0; c < 15; c++)
            send_hit(4'(c), 1'b0, 5'd0);
        chk_status(6'd7, 6'd6);
    endtask : t_steer

    // A transmit buffer inside the region is refused but still stepped over.
    task automatic t_tx();
        clr_all();
        wr(`OFS_DIR, 32'hffffffff);
        rd_chk("direction", `OFS_DIR, 32'h000000ff);
        wr(`OFS_DIR, 32'h00000002);
        wr(`OFS_CTRL, 32'h0);
        send_hit(4'hf, 1'b1, 5'd0);
        send_hit(4'hf, 1'b0, 5'd0);
        rd_chk("ovl_flags", `OFS_OVL, 32'h00000002);
        chk_status(6'd2, 6'd0);
        wr(`OFS_DIR, 32'h0);
    endtask : t_tx

    // Unmapped place and the read-only status word.
    task automatic t_bus();
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(8'h18, 32'hffffffff, r);
        chk("bresp_unmapped", {30'h0, `RESP_SLVERR}, {30'h0, r});
        axi_rd(8'h18, d, r);
        chk("rresp_unmapped", {30'h0, `RESP_SLVERR}, {30'h0, r});
        chk("rdata_unmapped", 32'h0, d);
        wr(`OFS_STATUS, 32'hffffffff);
        chk_status(6'd2, 6'd0);
    endtask : t_bus

    // Drives every input at time zero, resets, and runs the scenarios.
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
        clk_en = 1'b1;
        {awaddr, araddr, wdata, wstrb, code} = '0;
        err_count = 0;
        n_tests   = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_codes();
        t_fill();
        t_steer();
        t_tx();
        t_bus();
        wrap_up();
    end
endmodule : can_rx_fifo_pointer_logic_tb_top
